// ### sfb_flag_bank.sv
// sfb_flag_bank: latched supply and can fault flags with real time can state.
// assumes condition inputs are synchronous comparator levels from the
// analogue side and a master that keeps to the one cycle strobe protocol.
//
// Overview of operation
// (RL1) aux undervoltage latches after 100 us
// (RL2) aux overcurrent latches after 100 us
// (RL3) transceiver rail overtemperature latches at once
// (RL4) transceiver undervoltage latches after 100 us
// (RL5) transceiver overcurrent latches after 100 us
// (RL6) sense input low latches after 100 us
// (RL7) battery undervoltage latches after 100 us
// (RL8) main overcurrent in normal mode, filtered
// (RL9) low power overcurrent in rail-on mode, filtered
// (RL10) main rail thermal shutdown latches at once
// (RL11) reset low pulse under 100 ms latches
// (RL12) battery fail latches below fail level
// (RL13) driver state bit is real time
// (RL14) driver off by command or stuck transmit
// (RL15) receiver state real time, off in sleep
// (RL16) wake receiver enable, on after reset
// (RL17) real time status read changes nothing
// (RL18) can wake flag clears on read
// (RL19) can overtemperature latches, clears on read
// (RL20) read with condition present keeps flag
`timescale 1ns/1ns

module sfb_flag_bank
#(
  parameter int RST_SHORT_CYCLES = sfb_pkg::RST_SHORT_CYCLES  // shorten in simulation
)
(
  input  wire logic        CORE_CLK_IN,          // 20 mhz core clock
  input  wire logic        RST_IN,               // synchronous reset, active high
  input  wire logic [15:0] ADDR_IN,              // register address
  input  wire logic [15:0] WDATA_IN,             // write data
  input  wire logic        WR_IN,                // write strobe
  input  wire logic        RD_IN,                // read strobe
  input  wire logic        AUX_UV_IN,            // aux output below threshold
  input  wire logic        AUX_OC_IN,            // aux current above limit
  input  wire logic        XCVR_UV_IN,           // transceiver rail below threshold
  input  wire logic        XCVR_OC_IN,           // transceiver current above limit
  input  wire logic        XCVR_HOT_IN,          // transceiver regulator too hot
  input  wire logic        SENSE_LOW_IN,         // sense pin below threshold
  input  wire logic        VSUP_UV_IN,           // battery pin below low threshold
  input  wire logic        BATTERY_FAIL_FLAG_IN,           // battery pin below fail level
  input  wire logic        MAIN_OC_IN,           // main rail current above limit
  input  wire logic        LP_OC_IN,             // main rail above low power limit
  input  wire logic        NORMAL_MODE_IN,       // device in normal mode
  input  wire logic        LP_RAIL_ON_MODE_IN,   // low power with main rail kept on
  input  wire logic        MAIN_TSD_IN,          // main rail off for overtemperature
  input  wire logic        RESET_PIN_LOW_IN,     // reset pin seen low
  input  wire logic        CAN_WAKE_IN,          // can wake event pulse
  input  wire logic        CAN_HOT_IN,           // can thermal sensor above threshold
  input  wire logic        TXD_DOM_FAULT_IN,     // transmit input stuck dominant
  output logic      [15:0] RDATA_OUT,            // read data, cycle after strobe
  output logic             CAN_DRV_EN_OUT,       // can driver enabled
  output logic             CAN_RCV_EN_OUT,       // can receiver enabled
  output logic             WAKE_RX_EN_OUT        // can wake receiver enabled
);

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic [13:0] cond;                       // condition present, per flag
  logic [13:0] set_evt;                    // set event, per flag
  logic [13:0] flag;                       // latched flags
  logic [13:0] rd_clr;                     // flags addressed by this read
  logic [11:0] cnt [0:7];                  // filter counters
  logic [2:0]  can_ctrl;                   // software can control
  logic [20:0] rst_cnt;                    // reset pin low duration
  logic        rst_low_d;                  // reset pin level, last cycle
  logic        rst_pulse_short;            // low pulse ended under the limit
  logic [2:0]  rt_state;                   // real time can state
  logic [15:0] next_rdata;                 // read mux

  // address match; used by read, write and clear paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction : hit

  // ------------------------------------------------------------------
  // condition mapping
  // ------------------------------------------------------------------
  // main and low power overcurrent conditions only count in their own mode, so a mode change
  // ends the condition and lets a read clear the flag
  always_comb
  begin
    cond                          = '0;
    cond[sfb_pkg::FLG_AUX_UV]     = AUX_UV_IN;
    cond[sfb_pkg::FLG_AUX_OC]     = AUX_OC_IN;
    cond[sfb_pkg::FLG_XCVR_UV]    = XCVR_UV_IN;
    cond[sfb_pkg::FLG_XCVR_OC]    = XCVR_OC_IN;
    cond[sfb_pkg::FLG_SENSE_LOW]  = SENSE_LOW_IN;
    cond[sfb_pkg::FLG_VSUP_UV]    = VSUP_UV_IN;
    cond[sfb_pkg::FLG_MAIN_OC]    = MAIN_OC_IN & NORMAL_MODE_IN;      // [RL8]
    cond[sfb_pkg::FLG_LP_OC]      = LP_OC_IN & LP_RAIL_ON_MODE_IN;    // [RL9]
    cond[sfb_pkg::FLG_XCVR_HOT]   = XCVR_HOT_IN;
    cond[sfb_pkg::FLG_MAIN_TSD]   = MAIN_TSD_IN;
    cond[sfb_pkg::FLG_RST_SHORT]  = RESET_PIN_LOW_IN;
    cond[sfb_pkg::FLG_BATTERY_FAIL_FLAG]    = BATTERY_FAIL_FLAG_IN;
    cond[sfb_pkg::FLG_CAN_WAKE]   = 1'b0;   // wake flag needs only a read
    cond[sfb_pkg::FLG_CAN_HOT]    = CAN_HOT_IN;
  end

  // ------------------------------------------------------------------
  // 100 us filters
  // ------------------------------------------------------------------
  // each counter runs while its condition holds; the set fires in the
  // cycle after 2000 full cycles, so a condition must outlast the window
  genvar gi;
  generate
    for (gi = 0; gi < sfb_pkg::NUM_FILTERED; gi++)
    begin : g_filt
      always_ff @(posedge CORE_CLK_IN)
      begin
        if (RST_IN)
          cnt[gi] <= 12'h000;
        else if (!cond[gi])
          cnt[gi] <= 12'h000;                // any gap restarts the window
        else if (cnt[gi] != 12'(sfb_pkg::FILTER_CYCLES))
          cnt[gi] <= cnt[gi] + 12'h001;      // saturates at the limit
      end
      // filtered set: [RL1] [RL2] [RL4] [RL5] [RL6] [RL7] [RL8] [RL9]
      assign set_evt[gi] = cond[gi] && (cnt[gi] == 12'(sfb_pkg::FILTER_CYCLES));
    end
  endgenerate

  // ------------------------------------------------------------------
  // short reset pulse detector
  // ------------------------------------------------------------------
  // counts low time and saturates, so very long lows never look short
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      rst_cnt   <= 21'h000000;
      rst_low_d <= 1'b0;
    end
    else
    begin
      rst_low_d <= RESET_PIN_LOW_IN;
      if (!RESET_PIN_LOW_IN)
        rst_cnt <= 21'h000000;
      else if (rst_cnt != 21'(RST_SHORT_CYCLES))
        rst_cnt <= rst_cnt + 21'h000001;
    end
  end

  // pulse ends while count is still below the limit
  assign rst_pulse_short = rst_low_d && !RESET_PIN_LOW_IN
                           && (rst_cnt < 21'(RST_SHORT_CYCLES));   // [RL11]

  // ------------------------------------------------------------------
  // unfiltered set events
  // ------------------------------------------------------------------
  assign set_evt[sfb_pkg::FLG_XCVR_HOT]  = XCVR_HOT_IN;            // [RL3]
  assign set_evt[sfb_pkg::FLG_MAIN_TSD]  = MAIN_TSD_IN;            // [RL10]
  assign set_evt[sfb_pkg::FLG_RST_SHORT] = rst_pulse_short;        // [RL11]
  assign set_evt[sfb_pkg::FLG_BATTERY_FAIL_FLAG]   = BATTERY_FAIL_FLAG_IN;             // [RL12]
  assign set_evt[sfb_pkg::FLG_CAN_WAKE]  = CAN_WAKE_IN;            // [RL18]
  assign set_evt[sfb_pkg::FLG_CAN_HOT]   = CAN_HOT_IN;             // [RL19]

  // ------------------------------------------------------------------
  // read clear selection
  // ------------------------------------------------------------------
  // real time status and control reads select nothing here   [RL17]
  always_comb
  begin
    rd_clr = '0;
    if (RD_IN && hit(ADDR_IN, sfb_pkg::ADDR_SUPPLY_FLAGS))
      rd_clr = sfb_pkg::SUPPLY_MASK;
    else if (RD_IN && hit(ADDR_IN, sfb_pkg::ADDR_CAN_FLAGS))
      rd_clr = sfb_pkg::CAN_MASK;
  end

  // ------------------------------------------------------------------
  // flag latches
  // ------------------------------------------------------------------
  // set beats clear; a read only clears once the condition has gone, so
  // a read during a fault returns the flag and leaves it standing
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      flag <= 14'h0000;
    else
      flag <= set_evt | (flag & ~(rd_clr & ~cond));   // [RL20] [RL18] [RL19]
  end

  // ------------------------------------------------------------------
  // can control register
  // ------------------------------------------------------------------
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      can_ctrl <= sfb_pkg::CTRL_RESET;                  // [RL16]
    else if (WR_IN && hit(ADDR_IN, sfb_pkg::ADDR_CAN_CTRL))
      can_ctrl <= WDATA_IN[2:0];
  end

  // ------------------------------------------------------------------
  // real time can state
  // ------------------------------------------------------------------
  // driver is dropped by receive only, by sleep, or by a stuck transmit
  always_comb
  begin
    rt_state = '0;
    rt_state[sfb_pkg::RT_DRV_BIT]  = !can_ctrl[sfb_pkg::CTRL_RX_ONLY_BIT]
                                     && !can_ctrl[sfb_pkg::CTRL_CAN_SLEEP_BIT]
                                     && !TXD_DOM_FAULT_IN;              // [RL14]
    rt_state[sfb_pkg::RT_RCV_BIT]  = !can_ctrl[sfb_pkg::CTRL_CAN_SLEEP_BIT];  // [RL15]
    rt_state[sfb_pkg::RT_WAKE_BIT] = can_ctrl[sfb_pkg::CTRL_WAKE_RX_EN_BIT];  // [RL16]
  end

  // state pins registered so they come straight from flip-flops
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      CAN_DRV_EN_OUT <= 1'b0;
      CAN_RCV_EN_OUT <= 1'b0;
      WAKE_RX_EN_OUT <= 1'b0;
    end
    else
    begin
      CAN_DRV_EN_OUT <= rt_state[sfb_pkg::RT_DRV_BIT];    // [RL13]
      CAN_RCV_EN_OUT <= rt_state[sfb_pkg::RT_RCV_BIT];    // [RL15]
      WAKE_RX_EN_OUT <= rt_state[sfb_pkg::RT_WAKE_BIT];   // [RL16]
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  // unmapped addresses read as zero; data stands one cycle only
  always_comb
  begin
    next_rdata = 16'h0000;
    if (hit(ADDR_IN, sfb_pkg::ADDR_SUPPLY_FLAGS))
      next_rdata = {4'h0, flag[11:0]};
    else if (hit(ADDR_IN, sfb_pkg::ADDR_CAN_FLAGS))
      next_rdata = {14'h0000, flag[13:12]};
    else if (hit(ADDR_IN, sfb_pkg::ADDR_CAN_CTRL))
      next_rdata = {13'h0000, can_ctrl};
    else if (hit(ADDR_IN, sfb_pkg::ADDR_CAN_RT))
      next_rdata = {13'h0000, rt_state};                // [RL13]
  end

  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
      RDATA_OUT <= 16'h0000;
    else if (RD_IN)
      RDATA_OUT <= next_rdata;    // value before any read clear
    else
      RDATA_OUT <= 16'h0000;
  end

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  property p_aux_uv_set;   // [RL1]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (AUX_UV_IN && cnt[0] == 12'(sfb_pkg::FILTER_CYCLES)) |=> flag[0];
  endproperty
  a_aux_uv_set: assert property (p_aux_uv_set)   // [RL1]
    else $error("aux undervoltage flag not set after filter");

  property p_xcvr_uv_early;   // [RL4]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    $rose(flag[2]) |-> $past(cnt[2]) == 12'(sfb_pkg::FILTER_CYCLES);
  endproperty
  a_xcvr_uv_early: assert property (p_xcvr_uv_early)   // [RL4]
    else $error("transceiver undervoltage flag set before filter ended");

  property p_main_oc_mode;   // [RL8]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !NORMAL_MODE_IN |=> cnt[6] == 12'h000;
  endproperty
  a_main_oc_mode: assert property (p_main_oc_mode)   // [RL8]
    else $error("main overcurrent filter ran outside normal mode");

  property p_keep_on_read;   // [RL20]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (RD_IN && ADDR_IN == sfb_pkg::ADDR_SUPPLY_FLAGS && AUX_OC_IN && flag[1])
      |=> flag[1] && RDATA_OUT[1];
  endproperty
  a_keep_on_read: assert property (p_keep_on_read)   // [RL20]
    else $error("flag lost on read while condition present");

  property p_clear_on_read;   // [RL2]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (RD_IN && ADDR_IN == sfb_pkg::ADDR_SUPPLY_FLAGS && !AUX_OC_IN) |=> !flag[1];
  endproperty
  a_clear_on_read: assert property (p_clear_on_read)   // [RL2]
    else $error("flag not cleared by read after recovery");

  property p_wake_clear;   // [RL18]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (RD_IN && ADDR_IN == sfb_pkg::ADDR_CAN_FLAGS && !CAN_WAKE_IN) |=> !flag[12];
  endproperty
  a_wake_clear: assert property (p_wake_clear)   // [RL18]
    else $error("can wake flag survived a read");

  property p_rt_read_stable;   // [RL17]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    (RD_IN && ADDR_IN == sfb_pkg::ADDR_CAN_RT) |=> $stable(can_ctrl);
  endproperty
  a_rt_read_stable: assert property (p_rt_read_stable)   // [RL17]
    else $error("real time status read changed can control");

  property p_txd_fault;   // [RL14]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    TXD_DOM_FAULT_IN |=> !CAN_DRV_EN_OUT;
  endproperty
  a_txd_fault: assert property (p_txd_fault)   // [RL14]
    else $error("driver still enabled with transmit stuck dominant");

  property p_wake_default;   // [RL16]
    @(posedge CORE_CLK_IN)
    RST_IN ##1 !RST_IN |=> WAKE_RX_EN_OUT;
  endproperty
  a_wake_default: assert property (p_wake_default)   // [RL16]
    else $error("wake receiver not enabled after reset");

  property p_tsd_set;   // [RL10]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    MAIN_TSD_IN |=> flag[9] [*2];
  endproperty
  a_tsd_set: assert property (p_tsd_set)   // [RL10]
    else $error("thermal shutdown flag not held");

  property p_rst_short;   // [RL11]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    ($fell(RESET_PIN_LOW_IN) && rst_cnt < 21'(RST_SHORT_CYCLES)) |=> flag[10];
  endproperty
  a_rst_short: assert property (p_rst_short)   // [RL11]
    else $error("short reset pulse not flagged");

  // low power gate: leaving the mode must empty the filter
  property p_lp_oc_mode;   // [RL9]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    !LP_RAIL_ON_MODE_IN |=> cnt[7] == 12'h000;
  endproperty
  a_lp_oc_mode: assert property (p_lp_oc_mode)   // [RL9]
    else $error("low power overcurrent filter ran outside its mode");

  // unfiltered flags latch on the next edge
  property p_battery_fail_flag_set;   // [RL12]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    BATTERY_FAIL_FLAG_IN |=> flag[11];
  endproperty
  a_battery_fail_flag_set: assert property (p_battery_fail_flag_set)   // [RL12]
    else $error("battery fail flag not set");

  property p_can_hot_set;   // [RL19]
    @(posedge CORE_CLK_IN) disable iff (RST_IN)
    CAN_HOT_IN |=> flag[13];
  endproperty
  a_can_hot_set: assert property (p_can_hot_set)   // [RL19]
    else $error("can overtemperature flag not set");

endmodule : sfb_flag_bank

// ### sfb_host_model.sv
// sfb_host_model: register port master standing in for the host controller.
// assumes one clock shared with the flag bank; the bench calls its tasks.
`timescale 1ns/1ns

module sfb_host_model
(
  input  wire logic        clk_in,     // core clock
  output logic      [15:0] addr_out,   // register address
  output logic      [15:0] wdata_out,  // write data
  output logic             wr_out,     // write strobe
  output logic             rd_out      // read strobe
);
  // ------------------------------------------------------------------
  // idle bus at time zero
  // ------------------------------------------------------------------
  initial
  begin
    addr_out  = 16'h0000;
    wdata_out = 16'h0000;
    wr_out    = 1'b0;
    rd_out    = 1'b0;
  end

  // one cycle write strobe, all qualifiers held through the sampling edge
  task automatic bus_write(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= d;
    wr_out    <= 1'b1;
    @(posedge clk_in);
    wr_out    <= 1'b0;
    wdata_out <= ~d;  // stale data would hide a write that lands late
  endtask : bus_write

  // one cycle read strobe; data is picked up by the bench monitor
  task automatic bus_read(input logic [15:0] a);
    @(posedge clk_in);
    addr_out <= a;
    rd_out   <= 1'b1;
    @(posedge clk_in);
    rd_out   <= 1'b0;
    addr_out <= ~a;   // address must not matter once strobe is gone
  endtask : bus_read

endmodule : sfb_host_model

// ### sfb_pkg.sv
// sfb_pkg: constants for the supply and can fault flag bank.
// assumes a single 20 mhz core clock and a plain strobe register port.
package sfb_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ            = 20_000_000;   // core clock rate
  localparam int FILTER_TIME_US    = 100;          // deglitch time, microseconds
  // longest time, so round down; 2000 cycles
  localparam int FILTER_CYCLES     = (FILTER_TIME_US * (CLK_HZ / 1_000_000));
  localparam int FILTER_W          = 12;           // counter width for the filter
  localparam int RST_SHORT_TIME_MS = 100;          // short reset pulse limit, ms
  // default cycle count for the short reset pulse limit
  localparam int RST_SHORT_CYCLES  = (RST_SHORT_TIME_MS * (CLK_HZ / 1_000));
  localparam int RST_CNT_W         = 21;           // counter width for reset pulse

  // ------------------------------------------------------------------
  // register port
  // ------------------------------------------------------------------
  localparam int ADDR_W = 16;                      // address width
  localparam int DATA_W = 16;                      // data width
  localparam logic [15:0] ADDR_SUPPLY_FLAGS = 16'h0000;  // latched supply flags
  localparam logic [15:0] ADDR_CAN_FLAGS    = 16'h0004;  // latched can flags
  localparam logic [15:0] ADDR_CAN_CTRL     = 16'h0008;  // can control
  localparam logic [15:0] ADDR_CAN_RT       = 16'h2180;  // can real time status

  // can control fields and reset value (wake receiver on after power up)
  localparam int CTRL_RX_ONLY_BIT    = 0;
  localparam int CTRL_CAN_SLEEP_BIT  = 1;
  localparam int CTRL_WAKE_RX_EN_BIT = 2;
  localparam logic [2:0] CTRL_RESET  = 3'h4;

  // can real time fields
  localparam int RT_DRV_BIT  = 0;
  localparam int RT_RCV_BIT  = 1;
  localparam int RT_WAKE_BIT = 2;

  // ------------------------------------------------------------------
  // flag positions; filtered flags occupy the low indices
  // ------------------------------------------------------------------
  localparam int NUM_FLAGS      = 14;
  localparam int NUM_FILTERED   = 8;
  localparam int FLG_AUX_UV     = 0;
  localparam int FLG_AUX_OC     = 1;
  localparam int FLG_XCVR_UV    = 2;
  localparam int FLG_XCVR_OC    = 3;
  localparam int FLG_SENSE_LOW  = 4;
  localparam int FLG_VSUP_UV    = 5;
  localparam int FLG_MAIN_OC    = 6;
  localparam int FLG_LP_OC      = 7;
  localparam int FLG_XCVR_HOT   = 8;
  localparam int FLG_MAIN_TSD   = 9;
  localparam int FLG_RST_SHORT  = 10;
  localparam int FLG_BATTERY_FAIL_FLAG    = 11;
  localparam int FLG_CAN_WAKE   = 12;
  localparam int FLG_CAN_HOT    = 13;
  localparam logic [13:0] SUPPLY_MASK = 14'h0FFF;  // flags in the supply register
  localparam logic [13:0] CAN_MASK    = 14'h3000;  // flags in the can register
  localparam int CAN_FLAG_SHIFT       = 12;        // can flags start at bit 0 on read

endpackage : sfb_pkg

// ### tb_top.sv
// tb_top: self-checking bench for the supply and can fault flag bank.
// assumes sfb_pkg, sfb_flag_bank and sfb_host_model are compiled first.
`timescale 1ns/1ns

module tb_top;
  // ------------------------------------------------------------------
  // stimulus and observation
  // ------------------------------------------------------------------
  localparam int          RST_SHORT = 50;        // shortened reset pulse limit
  localparam logic [15:0] ADDR_NONE = 16'h0010;  // unmapped address
  logic        clk         = 1'b0;   // core clock
  logic        rst         = 1'b1;   // synchronous reset
  logic [13:0] cond        = 14'h0;  // condition levels by flag index
  logic        normal_mode = 1'b1;   // mode gate for main overcurrent
  logic        lp_on_mode  = 1'b1;   // mode gate for low power overcurrent
  logic        txd_fault   = 1'b0;   // transmit stuck dominant
  logic [15:0] addr;                 // bus from host model
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic        rd_d        = 1'b0;   // read seen one edge ago
  logic [15:0] rdata;
  logic        drv_en;
  logic        rcv_en;
  logic        wake_en;
  logic [15:0] exp_q[$];             // expected read words, oldest first
  int          err_count   = 0;
  int          checks_done = 0;
  integer      seed        = 25138;

  initial
  begin
    forever #25 clk = ~clk;
  end

  sfb_host_model host (.clk_in(clk), .addr_out(addr), .wdata_out(wdata),
                       .wr_out(wr), .rd_out(rd));

  sfb_flag_bank #(.RST_SHORT_CYCLES(RST_SHORT)) DUT (
    .CORE_CLK_IN(clk), .RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd),
    .AUX_UV_IN(cond[sfb_pkg::FLG_AUX_UV]), .AUX_OC_IN(cond[sfb_pkg::FLG_AUX_OC]),
    .XCVR_UV_IN(cond[sfb_pkg::FLG_XCVR_UV]), .XCVR_OC_IN(cond[sfb_pkg::FLG_XCVR_OC]),
    .XCVR_HOT_IN(cond[sfb_pkg::FLG_XCVR_HOT]), .SENSE_LOW_IN(cond[sfb_pkg::FLG_SENSE_LOW]),
    .VSUP_UV_IN(cond[sfb_pkg::FLG_VSUP_UV]), .BATTERY_FAIL_FLAG_IN(cond[sfb_pkg::FLG_BATTERY_FAIL_FLAG]),
    .MAIN_OC_IN(cond[sfb_pkg::FLG_MAIN_OC]), .LP_OC_IN(cond[sfb_pkg::FLG_LP_OC]),
    .NORMAL_MODE_IN(normal_mode), .LP_RAIL_ON_MODE_IN(lp_on_mode),
    .MAIN_TSD_IN(cond[sfb_pkg::FLG_MAIN_TSD]),
    .RESET_PIN_LOW_IN(cond[sfb_pkg::FLG_RST_SHORT]),
    .CAN_WAKE_IN(cond[sfb_pkg::FLG_CAN_WAKE]), .CAN_HOT_IN(cond[sfb_pkg::FLG_CAN_HOT]),
    .TXD_DOM_FAULT_IN(txd_fault), .RDATA_OUT(rdata), .CAN_DRV_EN_OUT(drv_en),
    .CAN_RCV_EN_OUT(rcv_en), .WAKE_RX_EN_OUT(wake_en));

  // ------------------------------------------------------------------
  // compare tasks and closing report
  // ------------------------------------------------------------------
  task automatic chk_word(input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_state(input logic [2:0] exp);
    checks_done++;
    if ({wake_en, rcv_en, drv_en} !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: can state %b expected %b", $time,
               {wake_en, rcv_en, drv_en}, exp);
    end
  endtask : chk_state

  task automatic final_report();
    if (exp_q.size() != 0)
    begin
      err_count++;
      $display("MISMATCH at %0t: %0d reads never answered", $time, exp_q.size());
    end
    $display("checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // monitor: read data stands only in the cycle after the strobe edge
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk)
  begin
    if (rd_d === 1'b1 && exp_q.size() > 0)
      chk_word(exp_q.pop_front(), rdata);
    else if (rd_d === 1'b1)
    begin
      err_count++;
      $display("MISMATCH at %0t: read data with no expectation", $time);
    end
  end

  // ------------------------------------------------------------------
  // scenario tasks
  // ------------------------------------------------------------------
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    host.bus_read(a);
  endtask : rd_chk

  // raise a condition, optional glitch restart and early look, then
  // read while present (must stay set), drop it, read clears once
  task automatic flag_test(input int f, input int pre, input int early);
    logic [15:0] a;
    logic [15:0] m;
    a = (f < 12) ? sfb_pkg::ADDR_SUPPLY_FLAGS : sfb_pkg::ADDR_CAN_FLAGS;
    m = 16'h0001 << ((f < 12) ? f : f - 12);
    @(posedge clk);
    cond[f] <= 1'b1;
    if (pre > 0)
    begin
      repeat (pre) @(posedge clk);
      cond[f] <= 1'b0;
      @(posedge clk);
      cond[f] <= 1'b1;
    end
    if (early > 0)
    begin
      repeat (early) @(posedge clk);
      rd_chk(a, 16'h0000);
    end
    repeat (20) @(posedge clk);
    rd_chk(a, m);
    rd_chk(a, m);
    @(posedge clk);
    cond[f] <= 1'b0;
    rd_chk(a, m);
    rd_chk(a, 16'h0000);
  endtask : flag_test

  // overcurrent held long with both mode gates low must not latch
  task automatic gate_test(input int f);
    @(posedge clk);
    cond[f]     <= 1'b1;
    normal_mode <= 1'b0;
    lp_on_mode  <= 1'b0;
    repeat (2100) @(posedge clk);
    rd_chk(sfb_pkg::ADDR_SUPPLY_FLAGS, 16'h0000);
    cond[f]     <= 1'b0;
    normal_mode <= 1'b1;
    lp_on_mode  <= 1'b1;
  endtask : gate_test

  // reset pin low for n cycles, then two reads of the supply flags
  task automatic rst_pulse(input int n, input logic [15:0] exp);
    @(posedge clk);
    cond[sfb_pkg::FLG_RST_SHORT] <= 1'b1;
    repeat (n) @(posedge clk);
    cond[sfb_pkg::FLG_RST_SHORT] <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(sfb_pkg::ADDR_SUPPLY_FLAGS, exp);
    rd_chk(sfb_pkg::ADDR_SUPPLY_FLAGS, 16'h0000);
  endtask : rst_pulse

  // ------------------------------------------------------------------
  // main sequence and hang guard
  // ------------------------------------------------------------------
  initial
  begin : main_seq
    logic [15:0] wd;
    logic [2:0]  rt;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk_state(3'h7);
    rd_chk(sfb_pkg::ADDR_CAN_CTRL, 16'h0004);
    rd_chk(sfb_pkg::ADDR_CAN_RT, 16'h0007);
    for (int i = 0; i < 6; i++)
    begin
      wd = 16'($random(seed));
      @(posedge clk);
      txd_fault <= wd[15];
      host.bus_write(sfb_pkg::ADDR_CAN_CTRL, wd);
      rt = {wd[2], ~wd[1], ~wd[0] & ~wd[1] & ~wd[15]};
      repeat (2) @(posedge clk);
      #1 chk_state(rt);
      rd_chk(sfb_pkg::ADDR_CAN_CTRL, {13'h0000, wd[2:0]});
      rd_chk(sfb_pkg::ADDR_CAN_RT, {13'h0000, rt});
      rd_chk(sfb_pkg::ADDR_CAN_RT, {13'h0000, rt});
      #1 chk_state(rt);
    end
    host.bus_write(sfb_pkg::ADDR_SUPPLY_FLAGS, 16'hFFFF);
    rd_chk(sfb_pkg::ADDR_SUPPLY_FLAGS, 16'h0000);
    rd_chk(ADDR_NONE, 16'h0000);
    flag_test(sfb_pkg::FLG_AUX_UV, 1500, 1990);
    flag_test(sfb_pkg::FLG_AUX_OC, 1500, 1990);
    flag_test(sfb_pkg::FLG_XCVR_UV, 1500, 1990);
    flag_test(sfb_pkg::FLG_XCVR_OC, 1500, 1990);
    flag_test(sfb_pkg::FLG_SENSE_LOW, 1500, 1990);
    flag_test(sfb_pkg::FLG_VSUP_UV, 1500, 1990);
    flag_test(sfb_pkg::FLG_MAIN_OC, 1500, 1990);
    flag_test(sfb_pkg::FLG_LP_OC, 1500, 1990);
    gate_test(sfb_pkg::FLG_MAIN_OC);
    gate_test(sfb_pkg::FLG_LP_OC);
    flag_test(sfb_pkg::FLG_XCVR_HOT, 0, 0);
    flag_test(sfb_pkg::FLG_MAIN_TSD, 0, 0);
    flag_test(sfb_pkg::FLG_BATTERY_FAIL_FLAG, 0, 0);
    flag_test(sfb_pkg::FLG_CAN_HOT, 0, 0);
    rst_pulse(RST_SHORT - 1, 16'h0400);
    rst_pulse(RST_SHORT, 16'h0000);
    @(posedge clk);
    cond[sfb_pkg::FLG_CAN_WAKE] <= 1'b1;
    @(posedge clk);
    cond[sfb_pkg::FLG_CAN_WAKE] <= 1'b0;
    rd_chk(sfb_pkg::ADDR_CAN_FLAGS, 16'h0001);
    rd_chk(sfb_pkg::ADDR_CAN_FLAGS, 16'h0000);
    repeat (4) @(posedge clk);
    final_report();
  end

  // no scenario may run this long; a hang ends the run as a failure
  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    $display("MISMATCH at %0t: run did not finish in time", $time);
    final_report();
  end

endmodule : tb_top
